//--- rtl/module_mgmt_consts.svh
// Address map, field positions and reset values of the management block
`ifndef MODULE_MGMT_CONSTS_SVH
`define MODULE_MGMT_CONSTS_SVH
`define BUS_ADDR_ID 7'h50
`define BUS_ADDR_DIAG 7'h51
`define THR_LAST 8'h27
`define LIVE_BASE 8'h60
`define LIVE_LAST 8'h69
`define ALM_BYTE0 8'h70
`define ALM_BYTE1 8'h71
`define WRN_BYTE0 8'h74
`define WRN_BYTE1 8'h75
`define SEL0_CTRL 8'h6E
`define SEL1_CTRL 8'h76
`define USER_BASE 8'h80
`define SOFT_BIT 3
`define SOFT_RESET 1'b1
`define BITS_PER_BYTE 4'h8
`define LAST_DATA_BIT 4'h7
`define SYNC_INIT 6'h18
`endif

//--- rtl/module_mgmt_pkg.sv
// Types shared by the management block
package module_mgmt_pkg;
    typedef enum logic [1:0] {
        lock_8g5,
        lock_10g,
        bypass
    } cdr_mode_t;
    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_word,
        st_write,
        st_read
    } link_state_t;
    typedef struct packed {
        logic [15:0] temperature;
        logic [15:0] supply;
        logic [15:0] bias;
        logic [15:0] tx_power;
        logic [15:0] rx_power;
    } monitor_t;
endpackage : module_mgmt_pkg

//--- rtl/module_mgmt_and_rate_select.sv
// Two-wire management slave, diagnostics map and clock-recovery mode decode
`timescale 1ns/1ps
`include "module_mgmt_consts.svh"

// Operation
// - Answer bus address A0h with the 256-byte identification map.
// - Serve diagnostics at bus address A2h; identification map stays unchanged.
// - Capture data on rising clock; write only unprotected bytes.
// - Shift read data onto the data line on the falling clock edge.
// - Start and stop conditions begin and end every transfer.
// - Byte-wide maps, single or sequential access with advancing address.
// - Diagnostics map shows live temperature, bias, powers and supply.
// - Alarm and warning flags set when readings leave factory limits.
// - Each effective rate select is pin OR its soft bit.
// - Both selects low: both recovery units lock at 8.5G.
// - Select zero low, one high: transmit bypassed, receive locks 10G.
// - Select zero high, one low: both units in bypass.
// - Both selects high: both units lock in the 10G range.
// - Both soft bits are one after power-up, giving 10G mode.
// - Rate-select pins pulled down; an open pin reads zero.
// - Host may rewrite soft bits; new mode applies after the write.
// - Low power level stops traffic; management keeps working.
// - Default power-up goes straight to full operation.
module module_mgmt_and_rate_select #(
    parameter logic [319:0] THRESHOLDS = '0,
    parameter logic [2047:0] ID_IMAGE = '0
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic rate_select_low_pin,
    input wire logic rate_select_high_pin,
    input wire logic low_power_level,
    input module_mgmt_pkg::monitor_t monitor,
    output module_mgmt_pkg::cdr_mode_t tx_cdr_mode,
    output module_mgmt_pkg::cdr_mode_t rx_cdr_mode,
    output logic traffic_enable
);

    // Start and stop detection on data line edges
    logic start_evt;
    logic start_lvl;
    logic stop_evt;
    logic stop_lvl;
    wire frame_raw = start_lvl ^ stop_lvl;

    always_ff @(negedge sda_in) begin
        if (srst) begin
            start_evt <= 1'b0;
            start_lvl <= 1'b0;
        end else if (scl_in) begin
            start_evt <= ~start_evt;
            start_lvl <= ~stop_lvl;
        end
    end

    always_ff @(posedge sda_in) begin
        if (srst) begin
            stop_evt <= 1'b0;
            stop_lvl <= 1'b0;
        end else if (scl_in) begin
            stop_evt <= ~stop_evt;
            stop_lvl <= start_lvl;
        end
    end

    // Link side, clocked by the host serial clock
    module_mgmt_pkg::link_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic [7:0] tx_byte;
    logic sel_diag;
    logic ack;
    logic start_seen;
    logic stop_seen;
    logic soft0;
    logic soft1;
    logic [7:0] user_mem [0:127];

    // Reference side snapshot, frozen while a frame is active
    logic [79:0] snap_mon;
    logic [9:0] snap_alm;
    logic [9:0] snap_wrn;

    wire new_start = start_evt ^ start_seen;
    wire new_stop = stop_evt ^ stop_seen;
    wire [7:0] rx_byte = {shreg[6:0], sda_in};
    wire addr_hit = rx_byte[7:1] == `BUS_ADDR_ID || rx_byte[7:1] == `BUS_ADDR_DIAG;
    wire byte_end = bit_cnt == `LAST_DATA_BIT && !new_start && !new_stop;
    wire wr_ok = sel_diag && (ptr[7] || ptr == `SEL0_CTRL || ptr == `SEL1_CTRL);
    wire wr_stb = state == module_mgmt_pkg::st_write && byte_end && wr_ok;

    // Read data selection
    wire [10:0] id_lsb = {~ptr, 3'h0};
    wire [7:0] id_byte = ID_IMAGE[id_lsb +: 8];
    wire [5:0] thr_idx = 6'(6'd39 - ptr[5:0]);
    wire [7:0] thr_byte = THRESHOLDS[{thr_idx, 3'h0} +: 8];
    wire [3:0] live_idx = 4'(4'd9 - ptr[3:0]);
    wire [7:0] live_byte = snap_mon[{live_idx, 3'h0} +: 8];
    wire in_live = ptr >= `LIVE_BASE && ptr <= `LIVE_LAST;
    wire [7:0] flag_byte = ptr == `ALM_BYTE0 ? snap_alm[9:2] :
        ptr == `ALM_BYTE1 ? {snap_alm[1:0], 6'h00} :
        ptr == `WRN_BYTE0 ? snap_wrn[9:2] :
        ptr == `WRN_BYTE1 ? {snap_wrn[1:0], 6'h00} : 8'h00;
    wire [7:0] diag_byte = ptr[7] ? user_mem[ptr[6:0]] :
        ptr <= `THR_LAST ? thr_byte :
        in_live ? live_byte :
        ptr == `SEL0_CTRL ? 8'(soft0) << `SOFT_BIT :
        ptr == `SEL1_CTRL ? 8'(soft1) << `SOFT_BIT : flag_byte;
    wire [7:0] rd_byte = sel_diag ? diag_byte : id_byte;

    always_ff @(posedge scl_in) begin
        if (srst) begin
            state <= module_mgmt_pkg::st_idle;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            tx_byte <= 8'h00;
            sel_diag <= 1'b0;
            ack <= 1'b0;
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
        end else begin
            start_seen <= start_evt;
            stop_seen <= stop_evt;
            shreg <= rx_byte;
            if (new_start) begin
                state <= module_mgmt_pkg::st_addr;
                bit_cnt <= 4'h1;
                ack <= 1'b0;
            end else if (new_stop || state == module_mgmt_pkg::st_idle) begin
                state <= module_mgmt_pkg::st_idle;
                bit_cnt <= 4'h0;
                ack <= 1'b0;
            end else if (bit_cnt == `BITS_PER_BYTE) begin
                bit_cnt <= 4'h0;
                if (state == module_mgmt_pkg::st_read) begin
                    if (!sda_in) begin
                        tx_byte <= rd_byte;
                        ptr <= ptr + 8'h01;
                    end else begin
                        state <= module_mgmt_pkg::st_idle;
                    end
                end
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == `LAST_DATA_BIT) begin
                    ack <= state != module_mgmt_pkg::st_read;
                    unique case (state)
                        module_mgmt_pkg::st_addr: begin
                            if (addr_hit) begin
                                sel_diag <= rx_byte[1];
                                state <= rx_byte[0] ? module_mgmt_pkg::st_read
                                    : module_mgmt_pkg::st_word;
                            end else begin
                                state <= module_mgmt_pkg::st_idle;
                                ack <= 1'b0;
                            end
                        end
                        module_mgmt_pkg::st_word: begin
                            ptr <= rx_byte;
                            state <= module_mgmt_pkg::st_write;
                        end
                        module_mgmt_pkg::st_write: ptr <= ptr + 8'h01;
                        module_mgmt_pkg::st_read: begin
                        end
                        module_mgmt_pkg::st_idle: begin
                        end
                    endcase
                end
            end
        end
    end

    // Writable storage and soft rate-select bits
    always_ff @(posedge scl_in) begin
        if (wr_stb && ptr[7]) begin
            user_mem[ptr[6:0]] <= rx_byte;
        end
    end

    always_ff @(posedge scl_in) begin
        if (srst) begin
            soft0 <= `SOFT_RESET;
            soft1 <= `SOFT_RESET;
        end else if (wr_stb && ptr == `SEL0_CTRL) begin
            soft0 <= rx_byte[`SOFT_BIT];
        end else if (wr_stb && ptr == `SEL1_CTRL) begin
            soft1 <= rx_byte[`SOFT_BIT];
        end
    end

    // Open-drain data line, driven on the falling clock edge
    assign sda_out = 1'b0;

    always_ff @(negedge scl_in) begin
        if (srst || new_start || new_stop) begin
            sda_oe <= 1'b0;
        end else if (bit_cnt == `BITS_PER_BYTE) begin
            sda_oe <= ack;
        end else if (state == module_mgmt_pkg::st_read) begin
            sda_oe <= ~tx_byte[3'(`LAST_DATA_BIT - bit_cnt)];
        end else begin
            sda_oe <= 1'b0;
        end
    end

    // Reference clock side: three-stage input filters
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync3;
    logic [5:0] filt;
    wire [5:0] async_in = {frame_raw, soft1, soft0, low_power_level,
        rate_select_high_pin, rate_select_low_pin};
    wire [5:0] next_filt = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1 <= `SYNC_INIT;
            sync2 <= `SYNC_INIT;
            sync3 <= `SYNC_INIT;
            filt <= `SYNC_INIT;
        end else begin
            sync1 <= async_in;
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= next_filt;
        end
    end

    // Rate-select decode
    wire eff0 = filt[0] | filt[3];
    wire eff1 = filt[1] | filt[4];
    wire module_mgmt_pkg::cdr_mode_t next_tx = (eff0 && eff1) ? module_mgmt_pkg::lock_10g :
        (!eff0 && !eff1) ? module_mgmt_pkg::lock_8g5 : module_mgmt_pkg::bypass;
    wire module_mgmt_pkg::cdr_mode_t next_rx = eff1 ? module_mgmt_pkg::lock_10g :
        eff0 ? module_mgmt_pkg::bypass : module_mgmt_pkg::lock_8g5;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tx_cdr_mode <= module_mgmt_pkg::lock_10g;
            rx_cdr_mode <= module_mgmt_pkg::lock_10g;
            traffic_enable <= 1'b1;
        end else begin
            tx_cdr_mode <= next_tx;
            rx_cdr_mode <= next_rx;
            traffic_enable <= ~filt[2];
        end
    end

    // Limit checks per monitored channel
    wire [79:0] mon_vec = monitor;
    logic [9:0] next_alm;
    logic [9:0] next_wrn;

    genvar c;
    generate
        for (c = 0; c < 5; c = c + 1) begin : g_chan
            localparam int TOP = 319 - 64 * c;
            wire [15:0] val = mon_vec[79 - 16 * c -: 16];
            assign next_alm[9 - 2 * c] = val > THRESHOLDS[TOP -: 16];
            assign next_alm[8 - 2 * c] = val < THRESHOLDS[TOP - 16 -: 16];
            assign next_wrn[9 - 2 * c] = val > THRESHOLDS[TOP - 32 -: 16];
            assign next_wrn[8 - 2 * c] = val < THRESHOLDS[TOP - 48 -: 16];
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            snap_mon <= 80'h0;
            snap_alm <= 10'h000;
            snap_wrn <= 10'h000;
        end else if (!filt[5]) begin
            snap_mon <= mon_vec;
            snap_alm <= next_alm;
            snap_wrn <= next_wrn;
        end
    end

    // Checks on the reference side
    property p_both_8g5;
        @(posedge ref_clk) disable iff (srst)
        (!eff0 && !eff1) |=> tx_cdr_mode == module_mgmt_pkg::lock_8g5
            && rx_cdr_mode == module_mgmt_pkg::lock_8g5;
    endproperty
    a_both_8g5: assert property (p_both_8g5) else $error("8.5G mode wrong");

    property p_tx_bypass;
        @(posedge ref_clk) disable iff (srst)
        (!eff0 && eff1) |=> tx_cdr_mode == module_mgmt_pkg::bypass
            && rx_cdr_mode == module_mgmt_pkg::lock_10g;
    endproperty
    a_tx_bypass: assert property (p_tx_bypass) else $error("tx bypass mode wrong");

    property p_all_bypass;
        @(posedge ref_clk) disable iff (srst)
        (eff0 && !eff1) |=> tx_cdr_mode == module_mgmt_pkg::bypass
            && rx_cdr_mode == module_mgmt_pkg::bypass;
    endproperty
    a_all_bypass: assert property (p_all_bypass) else $error("bypass mode wrong");

    property p_both_10g;
        @(posedge ref_clk) disable iff (srst)
        (filt[3] && filt[4]) |=> tx_cdr_mode == module_mgmt_pkg::lock_10g
            && rx_cdr_mode == module_mgmt_pkg::lock_10g;
    endproperty
    a_both_10g: assert property (p_both_10g) else $error("10G mode wrong");

    property p_low_power;
        @(posedge ref_clk) disable iff (srst)
        $rose(filt[2]) |=> !traffic_enable;
    endproperty
    a_low_power: assert property (p_low_power) else $error("traffic in low power");

    property p_power_up;
        @(posedge ref_clk) srst |=> traffic_enable;
    endproperty
    a_power_up: assert property (p_power_up) else $error("no traffic at power-up");

    property p_temp_alarm;
        @(posedge ref_clk) disable iff (srst)
        (!filt[5] && mon_vec[79:64] > THRESHOLDS[319:304]) |=> snap_alm[9];
    endproperty
    a_temp_alarm: assert property (p_temp_alarm) else $error("temp alarm missed");

    // Checks on the link side
    sequence s_addr_end;
        state == module_mgmt_pkg::st_addr && byte_end;
    endsequence

    property p_foreign_addr;
        @(posedge scl_in) disable iff (srst)
        s_addr_end ##0 !addr_hit |=> state == module_mgmt_pkg::st_idle && !sda_oe;
    endproperty
    a_foreign_addr: assert property (p_foreign_addr) else $error("foreign addr acked");

    property p_diag_addr;
        @(posedge scl_in) disable iff (srst)
        s_addr_end ##0 rx_byte[7:1] == `BUS_ADDR_DIAG |=> sel_diag && ack && sda_oe;
    endproperty
    a_diag_addr: assert property (p_diag_addr) else $error("diag addr not acked");

    property p_soft_write;
        @(posedge scl_in) disable iff (srst)
        (wr_stb && ptr == `SEL0_CTRL) |=> soft0 == $past(shreg[2]);
    endproperty
    a_soft_write: assert property (p_soft_write) else $error("soft bit not written");

    property p_ptr_step;
        @(posedge scl_in) disable iff (srst)
        (state == module_mgmt_pkg::st_write && byte_end) |=> ptr == $past(ptr) + 8'h01;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("address did not advance");

    property p_read_drive;
        @(posedge scl_in) disable iff (srst)
        (state == module_mgmt_pkg::st_read && bit_cnt < `BITS_PER_BYTE && !new_start
            && !new_stop && $past(state) == module_mgmt_pkg::st_read)
            |-> sda_oe == ~tx_byte[3'(`LAST_DATA_BIT - bit_cnt)];
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read bit wrong");

endmodule : module_mgmt_and_rate_select

//--- tb/i2c_host_model.sv
// Host controller model: two-wire bus master
`timescale 1ns/1ps
module i2c_host_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic reset_wiggle();
        #20 sda_low = 1'b1;
        #20 scl = 1'b0;
        #40 scl = 1'b1;
        #20 sda_low = 1'b0;
    endtask : reset_wiggle
    task automatic start();
        sda_low = 1'b0;
        #20 scl = 1'b1;
        #20 sda_low = 1'b1;
        #20 scl = 1'b0;
    endtask : start
    task automatic stop();
        #20 sda_low = 1'b1;
        #20 scl = 1'b1;
        #20 sda_low = 1'b0;
        #40;
    endtask : stop
    task automatic bit_io(input logic b, output logic seen);
        #20 sda_low = ~b;
        #20 scl = 1'b1;
        #20 seen = sda;
        #20 scl = 1'b0;
    endtask : bit_io
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask : send_byte
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(last, s);
    endtask : get_byte
endmodule : i2c_host_model

//--- tb/module_mgmt_and_rate_select_test.sv
// Self-checking bench of the management block
`timescale 1ns/1ps
`include "module_mgmt_consts.svh"
module module_mgmt_and_rate_select_test;
    localparam logic [319:0] THR = {5{64'h8000100070002000}};
    function automatic logic [2047:0] id_fill();
        logic [2047:0] v;
        for (int i = 0; i < 256; i++) begin
            v[2047 - 8 * i -: 8] = 8'(i) ^ 8'h5A;
        end
        return v;
    endfunction : id_fill
    logic ref_clk, srst, scl, host_sda_low, sda, sda_out, sda_oe, traffic_enable;
    logic rate_select_low_pin, rate_select_high_pin, low_power_level;
    module_mgmt_pkg::monitor_t monitor;
    module_mgmt_pkg::cdr_mode_t tx_cdr_mode, rx_cdr_mode;
    int fails = 0;
    int cmp_count = 0;
    assign sda = ~((sda_oe & ~sda_out) | host_sda_low);
    module_mgmt_and_rate_select #(.THRESHOLDS(THR), .ID_IMAGE(id_fill())) i_dut (
        .ref_clk(ref_clk), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .rate_select_low_pin(rate_select_low_pin),
        .rate_select_high_pin(rate_select_high_pin), .low_power_level(low_power_level),
        .monitor(monitor), .tx_cdr_mode(tx_cdr_mode), .rx_cdr_mode(rx_cdr_mode),
        .traffic_enable(traffic_enable));
    i2c_host_model i_host (.scl(scl), .sda_low(host_sda_low), .sda(sda));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    task automatic bus_write(input logic [6:0] dev, input logic [7:0] word,
                             input logic [7:0] data[$]);
        logic ack;
        i_host.start();
        i_host.send_byte({dev, 1'b0}, ack);
        check("address ack", {7'h00, ack}, 8'h01);
        i_host.send_byte(word, ack);
        foreach (data[i]) begin
            i_host.send_byte(data[i], ack);
            check("data ack", {7'h00, ack}, 8'h01);
        end
        i_host.stop();
    endtask : bus_write
    task automatic bus_read(input logic [6:0] dev, input logic [7:0] word, input int n,
                            output logic [7:0] got[$]);
        logic ack;
        logic [7:0] b;
        got = {};
        i_host.start();
        i_host.send_byte({dev, 1'b0}, ack);
        i_host.send_byte(word, ack);
        i_host.start();
        i_host.send_byte({dev, 1'b1}, ack);
        check("read ack", {7'h00, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            i_host.get_byte(i == n - 1, b);
            got.push_back(b);
        end
        i_host.stop();
    endtask : bus_read
    function automatic logic [1:0] exp_mode(input logic r0, input logic r1, input logic tx);
        if (!r0 && !r1) return module_mgmt_pkg::lock_8g5;
        if (r0 && r1) return module_mgmt_pkg::lock_10g;
        if (r0) return module_mgmt_pkg::bypass;
        return tx ? module_mgmt_pkg::bypass : module_mgmt_pkg::lock_10g;
    endfunction : exp_mode
    function automatic logic [9:0] exp_flags(input module_mgmt_pkg::monitor_t m,
                                             input logic warn);
        logic [15:0] v[5];
        logic [9:0] f;
        v = '{m.temperature, m.supply, m.bias, m.tx_power, m.rx_power};
        for (int i = 0; i < 5; i++) begin
            f[9 - 2 * i] = v[i] > (warn ? 16'h7000 : 16'h8000);
            f[8 - 2 * i] = v[i] < (warn ? 16'h2000 : 16'h1000);
        end
        return f;
    endfunction : exp_flags
    initial begin
        #2ms;
        fails++;
        give_verdict();
    end
    initial begin
        logic [7:0] got[$];
        logic [7:0] ram[$];
        logic [9:0] f;
        logic r0, r1;
        srst = 1'b1;
        rate_select_low_pin = 1'b0;
        rate_select_high_pin = 1'b0;
        low_power_level = 1'b0;
        monitor = '0;
        void'($urandom(32'hC41A7870));
        fork
            repeat (12) @(negedge ref_clk);
            i_host.reset_wiggle();
        join
        srst = 1'b0;
        repeat (8) @(negedge ref_clk);
        check("tx mode", 8'(tx_cdr_mode), 8'(module_mgmt_pkg::lock_10g));
        check("rx mode", 8'(rx_cdr_mode), 8'(module_mgmt_pkg::lock_10g));
        check("traffic", {7'h00, traffic_enable}, 8'h01);
        bus_read(`BUS_ADDR_DIAG, `SEL0_CTRL, 1, got);
        check("soft zero", got[0], 8'h08);
        bus_read(`BUS_ADDR_DIAG, `SEL1_CTRL, 1, got);
        check("soft one", got[0], 8'h08);
        $display("test defaults done");
        for (int s = 0; s < 4; s++) begin
            bus_write(`BUS_ADDR_DIAG, `SEL0_CTRL, '{{4'h0, s[0], 3'h0}});
            bus_write(`BUS_ADDR_DIAG, `SEL1_CTRL, '{{4'h0, s[1], 3'h0}});
            bus_read(`BUS_ADDR_DIAG, `SEL1_CTRL, 1, got);
            check("soft readback", got[0], {4'h0, s[1], 3'h0});
            bus_read(`BUS_ADDR_DIAG, `SEL0_CTRL, 1, got);
            check("soft zero readback", got[0], {4'h0, s[0], 3'h0});
            for (int p = 0; p < 4; p++) begin
                @(negedge ref_clk);
                rate_select_low_pin = p[0];
                rate_select_high_pin = p[1];
                repeat (8) @(negedge ref_clk);
                r0 = p[0] | s[0];
                r1 = p[1] | s[1];
                check("tx mode", 8'(tx_cdr_mode), 8'(exp_mode(r0, r1, 1'b1)));
                check("rx mode", 8'(rx_cdr_mode), 8'(exp_mode(r0, r1, 1'b0)));
            end
        end
        rate_select_low_pin = 1'b0;
        rate_select_high_pin = 1'b0;
        $display("test rate select done");
        bus_read(`BUS_ADDR_ID, 8'hFE, 4, got);
        foreach (got[i]) check("id byte", got[i], 8'(8'hFE + i) ^ 8'h5A);
        bus_write(`BUS_ADDR_ID, 8'h10, '{8'h33});
        bus_read(`BUS_ADDR_ID, 8'h10, 1, got);
        check("id protected", got[0], 8'h10 ^ 8'h5A);
        i_host.start();
        i_host.send_byte({7'h52, 1'b0}, r0);
        check("foreign ack", {7'h00, r0}, 8'h00);
        i_host.stop();
        $display("test id map done");
        for (int k = 0; k < 4; k++) begin
            @(negedge ref_clk);
            monitor = (k == 0) ? 80'h0800_8000_8001_1800_4000 :
                      80'({$urandom(), $urandom(), $urandom()});
            repeat (4) @(negedge ref_clk);
            bus_read(`BUS_ADDR_DIAG, `LIVE_BASE, 10, got);
            foreach (got[i]) check("live byte", got[i], monitor[79 - 8 * i -: 8]);
            f = exp_flags(monitor, 1'b0);
            bus_read(`BUS_ADDR_DIAG, `ALM_BYTE0, 2, got);
            check("alarm hi", got[0], f[9:2]);
            check("alarm lo", got[1], {f[1:0], 6'h00});
            f = exp_flags(monitor, 1'b1);
            bus_read(`BUS_ADDR_DIAG, `WRN_BYTE0, 2, got);
            check("warn hi", got[0], f[9:2]);
            check("warn lo", got[1], {f[1:0], 6'h00});
        end
        $display("test diagnostics done");
        ram = '{8'($urandom()), 8'($urandom()), 8'($urandom()), 8'($urandom())};
        bus_write(`BUS_ADDR_DIAG, 8'hFE - 8'h7E, ram);
        bus_read(`BUS_ADDR_DIAG, `USER_BASE, 4, got);
        foreach (got[i]) check("user ram", got[i], ram[i]);
        bus_write(`BUS_ADDR_DIAG, 8'h00, '{8'hFF});
        bus_read(`BUS_ADDR_DIAG, 8'h00, 1, got);
        check("threshold ro", got[0], 8'h80);
        $display("test write protect done");
        @(negedge ref_clk);
        low_power_level = 1'b1;
        repeat (8) @(negedge ref_clk);
        check("traffic off", {7'h00, traffic_enable}, 8'h00);
        bus_read(`BUS_ADDR_DIAG, `SEL0_CTRL, 1, got);
        check("bus in low power", got[0], 8'h08);
        low_power_level = 1'b0;
        repeat (8) @(negedge ref_clk);
        check("traffic on", {7'h00, traffic_enable}, 8'h01);
        $display("test low power done");
        give_verdict();
    end
endmodule : module_mgmt_and_rate_select_test
